/* verilog/sysint_pkg.sv */
// package of register offsets, bit positions, reset values and timing counts
// assumes a byte-wide register port with read data one cycle after the strobe
package sysint_pkg;
	localparam logic [15:0] ADDR_BREAK_EXIT    = 16'hfe00;
	localparam logic [15:0] ADDR_RESET_SOURCE  = 16'hfe01;
	localparam logic [15:0] ADDR_BREAK_CTRL    = 16'hfe03;
	localparam logic [15:0] ADDR_IRQ_FIRST     = 16'hfe04;
	localparam logic [15:0] ADDR_IRQ_SECOND    = 16'hfe05;
	localparam logic [15:0] ADDR_IRQ_THIRD     = 16'hfe06;

	localparam int BIT_BREAK_EXIT   = 1;
	localparam int BIT_CLEAR_ENABLE = 0;
	// reset source flag positions
	localparam int BIT_POWER_ON  = 7;
	localparam int BIT_PIN       = 6;
	localparam int BIT_WATCHDOG  = 5;
	localparam int BIT_BAD_OP    = 4;
	localparam int BIT_BAD_FETCH = 3;
	localparam int BIT_MONITOR   = 1;
	localparam int BIT_LOW_VOLT  = 0;

	localparam logic [7:0] RESET_SOURCE_INIT = 8'h80;
	localparam logic [7:0] BREAK_CTRL_INIT   = 8'h00;

	localparam int STOP_RECOVERY_LONG  = 4096;
	localparam int STOP_RECOVERY_SHORT = 32;
	localparam int COUNTER_WIDTH       = 13;
endpackage : sysint_pkg

/* verilog/sysint_core.sv */
// system integration: interrupt status, break control, wait and stop
// sequencing, reset source flags and break-exit flag
// assumes cpu, break and peripherals are synchronous to clk_sys_i;
// the crystal clock arrives as a one-cycle enable pulse on its falling edge
// How it works
// - first status register holds sources 1-6 in bits 7:2, bits 1:0 zero.
// - second status register holds sources 7-14 in all eight bits.
// - third status register holds sources 15-16 in bits 1:0, rest zero.
// - every reset source acts alike, first, without arbitration.
// - break request forces cpu to fetch the software interrupt vector.
// - in break with clear enable low, peripheral flag clears are blocked.
// - a flag cleared in break with enable set stays cleared afterwards.
// - two-step clears stay blocked in break with clear enable low; step two after break clears.
// - wait or stop clears the cpu interrupt mask and stops cpu clock.
// - wait gates cpu clocks while peripheral clocks keep running.
// - enabled interrupt wakes wait; stacking starts one cycle later.
// - reset or break also ends wait and stop; break sets exit flag.
// - watchdog runs during wait when its disable option is zero.
// - stop disables clocks; interrupt or break ends it after delay, reset at once.
// - stop disables bus clock and crystal clock outputs.
// - recovery is 4096 crystal cycles, 32 with short recovery option.
// - system counter held reset during stop, then times the recovery.
// - break-exit flag clears on a written zero and on any reset.
// - reading reset status clears it; power-on sets only its own flag.
// - reset cause flags: pin, watchdog, opcode, fetch, monitor, brownout.
// - monitor flag set on monitor entry with blank vectors and irq high.
// - clear enable bit one allows clears in break, zero blocks them.
// - counter is 13 bits and steps on the crystal clock falling edge.
module sysint_core #(
	parameter int RECOVERY_LONG  = sysint_pkg::STOP_RECOVERY_LONG,
	parameter int RECOVERY_SHORT = sysint_pkg::STOP_RECOVERY_SHORT
) (
	input  wire logic        clk_sys_i,
	input  wire logic        sys_rst_i,
	input  wire logic [15:0] reg_addr_i,
	input  wire logic [7:0]  reg_wdata_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	output logic      [7:0]  reg_rdata_o,
	input  wire logic [16:1] irq_source_i,
	input  wire logic        irq_enabled_i,
	input  wire logic        break_req_i,
	input  wire logic        wait_exec_i,
	input  wire logic        stop_exec_i,
	input  wire logic        crystal_fall_i,
	input  wire logic        short_stop_recovery_i,
	input  wire logic        watchdog_disable_option_i,
	input  wire logic        power_on_i,
	input  wire logic        rst_pin_i,
	input  wire logic        rst_watchdog_i,
	input  wire logic        rst_bad_opcode_i,
	input  wire logic        rst_bad_fetch_i,
	input  wire logic        rst_monitor_i,
	input  wire logic        rst_low_voltage_i,
	input  wire logic        flag_clear_req_i,
	output logic             flag_clear_allow_o,
	output logic             force_software_interrupt_o,
	output logic             clear_int_mask_o,
	output logic             stack_start_o,
	output logic             system_reset_o,
	output logic             cpu_clock_en_o,
	output logic             periph_clock_en_o,
	output logic             generator_bus_clock_en_o,
	output logic             crystal_clock_en_o,
	output logic             watchdog_run_o,
	output logic             counter_overflow_o
);
	// the recovery counter cannot time more than its own range
	if (RECOVERY_SHORT < 1 || RECOVERY_SHORT > RECOVERY_LONG
		|| RECOVERY_LONG > (1 << sysint_pkg::COUNTER_WIDTH))
	begin : g_bad_recovery
		$error("stop recovery counts out of range");
	end

	typedef enum {RUN, WAITING, STOPPED, RECOVER} power_state_t;

	localparam logic [12:0] LONG_LAST  = 13'(RECOVERY_LONG - 1);
	localparam logic [12:0] SHORT_LAST = 13'(RECOVERY_SHORT - 1);

	// -------------------------------------------------------------------
	// power sequencing
	// -------------------------------------------------------------------
	power_state_t state;
	power_state_t next_state;
	logic [12:0]  counter;
	logic [12:0]  next_counter;
	logic         in_break;
	logic         next_in_break;
	logic         break_exit;
	logic         next_break_exit;
	logic         wake_break;
	logic         next_stack_pend;
	logic         any_reset;
	logic         wake_irq;
	logic [12:0]  last_count;

	assign any_reset  = power_on_i | rst_pin_i | rst_watchdog_i
		| rst_bad_opcode_i | rst_bad_fetch_i | rst_monitor_i
		| rst_low_voltage_i;
	assign wake_irq   = (|irq_source_i) & irq_enabled_i;
	assign last_count = short_stop_recovery_i ? SHORT_LAST : LONG_LAST;

	always_comb begin
		next_state      = state;
		next_counter    = counter;
		next_stack_pend = 1'b0;
		wake_break      = 1'b0;
		case (state)
			RUN: begin
				if (crystal_fall_i)
					next_counter = counter + 13'h0001;
				if (stop_exec_i) begin
					next_state   = STOPPED;
					next_counter = 13'h0000;
				end else if (wait_exec_i)
					next_state = WAITING;
			end
			WAITING: begin
				if (crystal_fall_i)
					next_counter = counter + 13'h0001;
				if (break_req_i || wake_irq) begin
					next_state      = RUN;
					next_stack_pend = 1'b1;
					wake_break      = break_req_i;
				end
			end
			STOPPED: begin
				next_counter = 13'h0000;
				if (break_req_i || wake_irq) begin
					next_state = RECOVER;
					wake_break = break_req_i;
				end
			end
			RECOVER: begin
				if (crystal_fall_i) begin
					next_counter = counter + 13'h0001;
					if (counter == last_count) begin
						next_state      = RUN;
						next_stack_pend = 1'b1;
					end
				end
			end
			default: next_state = RUN;
		endcase
		// a reset leaves low power at once and never stacks
		if (any_reset) begin
			next_state      = RUN;
			next_stack_pend = 1'b0;
		end
	end

	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state   <= RUN;
			counter <= 13'h0000;
		end else begin
			state   <= next_state;
			counter <= next_counter;
		end
	end

	// -------------------------------------------------------------------
	// break state and break-exit flag
	// -------------------------------------------------------------------
	always_comb begin
		next_in_break   = in_break;
		next_break_exit = break_exit;
		// break holds until the cpu stacks with no new break request
		if (break_req_i)
			next_in_break = 1'b1;
		else if (stack_start_o)
			next_in_break = 1'b0;
		if (reg_wr_i && reg_addr_i == sysint_pkg::ADDR_BREAK_EXIT
			&& !reg_wdata_i[sysint_pkg::BIT_BREAK_EXIT])
			next_break_exit = 1'b0;
		// the hardware set wins over a written zero in the same cycle
		if (wake_break)
			next_break_exit = 1'b1;
		if (any_reset) begin
			next_in_break   = 1'b0;
			next_break_exit = 1'b0;
		end
	end

	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			in_break   <= 1'b0;
			break_exit <= 1'b0;
		end else begin
			in_break   <= next_in_break;
			break_exit <= next_break_exit;
		end
	end

	// -------------------------------------------------------------------
	// reset source flags
	// -------------------------------------------------------------------
	logic [7:0] reset_flags;
	logic [7:0] next_reset_flags;
	logic       clear_enable;
	logic       next_clear_enable;
	logic [7:0] next_rdata;
	logic       rd_reset;

	assign rd_reset = reg_rd_i && reg_addr_i == sysint_pkg::ADDR_RESET_SOURCE;

	always_comb begin
		next_reset_flags = reset_flags;
		if (rd_reset)
			next_reset_flags = 8'h00;
		// a cause that meets the clearing read is kept, not lost
		if (rst_pin_i)
			next_reset_flags[sysint_pkg::BIT_PIN] = 1'b1;
		if (rst_watchdog_i)
			next_reset_flags[sysint_pkg::BIT_WATCHDOG] = 1'b1;
		if (rst_bad_opcode_i)
			next_reset_flags[sysint_pkg::BIT_BAD_OP] = 1'b1;
		if (rst_bad_fetch_i)
			next_reset_flags[sysint_pkg::BIT_BAD_FETCH] = 1'b1;
		if (rst_monitor_i)
			next_reset_flags[sysint_pkg::BIT_MONITOR] = 1'b1;
		if (rst_low_voltage_i)
			next_reset_flags[sysint_pkg::BIT_LOW_VOLT] = 1'b1;
		// power-on overrides every other cause
		if (power_on_i)
			next_reset_flags = sysint_pkg::RESET_SOURCE_INIT;
	end

	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			reset_flags <= sysint_pkg::RESET_SOURCE_INIT;
		else
			reset_flags <= next_reset_flags;
	end

	// -------------------------------------------------------------------
	// break clear enable
	// -------------------------------------------------------------------
	always_comb begin
		next_clear_enable = clear_enable;
		if (reg_wr_i && reg_addr_i == sysint_pkg::ADDR_BREAK_CTRL)
			next_clear_enable = reg_wdata_i[sysint_pkg::BIT_CLEAR_ENABLE];
	end

	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			clear_enable <= sysint_pkg::BREAK_CTRL_INIT[0];
		else
			clear_enable <= next_clear_enable;
	end

	// -------------------------------------------------------------------
	// read data
	// -------------------------------------------------------------------
	// read data stand for one cycle only and are zero otherwise
	always_comb begin
		next_rdata = 8'h00;
		if (reg_rd_i) begin
			case (reg_addr_i)
				sysint_pkg::ADDR_BREAK_EXIT:
					next_rdata[sysint_pkg::BIT_BREAK_EXIT] = break_exit;
				sysint_pkg::ADDR_RESET_SOURCE: next_rdata = reset_flags;
				sysint_pkg::ADDR_BREAK_CTRL:
					next_rdata[sysint_pkg::BIT_CLEAR_ENABLE] = clear_enable;
				sysint_pkg::ADDR_IRQ_FIRST:
					next_rdata = {irq_source_i[6:1], 2'b00};
				sysint_pkg::ADDR_IRQ_SECOND:
					next_rdata = irq_source_i[14:7];
				sysint_pkg::ADDR_IRQ_THIRD:
					next_rdata = {6'h00, irq_source_i[16:15]};
				default: next_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			reg_rdata_o <= 8'h00;
		else
			reg_rdata_o <= next_rdata;
	end

	// -------------------------------------------------------------------
	// registered control outputs
	// -------------------------------------------------------------------
	logic next_clear_allow;
	logic next_force_vector;
	logic next_mask_clear;
	logic next_stack_start;
	logic next_system_reset;
	logic next_cpu_clock_en;
	logic next_periph_clock_en;
	logic next_bus_clock_en;
	logic next_crystal_clock_en;
	logic next_watchdog_run;
	logic next_overflow;

	always_comb begin
		// a pending two-step clear completes only outside a blocked break
		next_clear_allow = flag_clear_req_i && (!next_in_break
			|| next_clear_enable);
		next_force_vector = break_req_i;
		next_mask_clear = state == RUN && (stop_exec_i || wait_exec_i)
			&& !any_reset;
		next_stack_start = next_stack_pend;
		next_system_reset = any_reset;
		next_cpu_clock_en = next_state == RUN;
		next_periph_clock_en = next_state == RUN
			|| next_state == WAITING;
		next_bus_clock_en = next_state != STOPPED;
		next_crystal_clock_en = next_state != STOPPED;
		next_watchdog_run = !watchdog_disable_option_i
			&& (next_state == RUN || next_state == WAITING);
		// the counter is held in stop and busy timing recovery
		next_overflow = crystal_fall_i && counter == 13'h1fff
			&& state != RECOVER && state != STOPPED;
	end

	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			flag_clear_allow_o         <= 1'b0;
			force_software_interrupt_o <= 1'b0;
			clear_int_mask_o           <= 1'b0;
			stack_start_o              <= 1'b0;
			system_reset_o             <= 1'b1;
			cpu_clock_en_o             <= 1'b1;
			periph_clock_en_o          <= 1'b1;
			generator_bus_clock_en_o   <= 1'b1;
			crystal_clock_en_o         <= 1'b1;
			watchdog_run_o             <= 1'b0;
			counter_overflow_o         <= 1'b0;
		end else begin
			flag_clear_allow_o         <= next_clear_allow;
			force_software_interrupt_o <= next_force_vector;
			clear_int_mask_o           <= next_mask_clear;
			stack_start_o              <= next_stack_start;
			system_reset_o             <= next_system_reset;
			cpu_clock_en_o             <= next_cpu_clock_en;
			periph_clock_en_o          <= next_periph_clock_en;
			generator_bus_clock_en_o   <= next_bus_clock_en;
			crystal_clock_en_o         <= next_crystal_clock_en;
			watchdog_run_o             <= next_watchdog_run;
			counter_overflow_o         <= next_overflow;
		end
	end
endmodule : sysint_core

/* testbench/sysint_core_props.sv */
// checker of port timing for the system integration core
// assumes every output is registered one cycle behind its cause
module sysint_core_props (
	input wire logic        clk_sys_i,
	input wire logic        sys_rst_i,
	input wire logic [15:0] reg_addr_i,
	input wire logic        reg_rd_i,
	input wire logic [7:0]  reg_rdata_o,
	input wire logic [16:1] irq_source_i,
	input wire logic        irq_enabled_i,
	input wire logic        break_req_i,
	input wire logic        wait_exec_i,
	input wire logic        stop_exec_i,
	input wire logic        rst_pin_i,
	input wire logic        rst_low_voltage_i,
	input wire logic        crystal_fall_i,
	input wire logic        counter_overflow_o,
	input wire logic        force_software_interrupt_o,
	input wire logic        clear_int_mask_o,
	input wire logic        stack_start_o,
	input wire logic        system_reset_o,
	input wire logic        cpu_clock_en_o,
	input wire logic        periph_clock_en_o,
	input wire logic        generator_bus_clock_en_o,
	input wire logic        crystal_clock_en_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (sys_rst_i);
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	break_vector_a: assert property (
		break_req_i |=> force_software_interrupt_o)
		else $error("break did not force the vector");
	mask_clear_a: assert property (
		(wait_exec_i || stop_exec_i) |=> clear_int_mask_o)
		else $error("mask not cleared on low power entry");
	wait_gate_a: assert property (
		wait_exec_i |=> !cpu_clock_en_o && periph_clock_en_o)
		else $error("wait clock gating wrong");
	stop_clock_a: assert property (
		stop_exec_i |=> !generator_bus_clock_en_o && !crystal_clock_en_o)
		else $error("stop left a generator output on");
	stop_hold_a: assert property (
		stop_exec_i |=> (!cpu_clock_en_o)[*3])
		else $error("stop released cpu clock too early");
	wake_stack_a: assert property (
		!cpu_clock_en_o && periph_clock_en_o && irq_enabled_i
		&& |irq_source_i |=> stack_start_o)
		else $error("wait wake stacking late");
	reset_first_a: assert property (
		(rst_pin_i || rst_low_voltage_i) |=> system_reset_o)
		else $error("reset source not taken");
	irq_low_zero_a: assert property (
		$past(reg_rd_i) && $past(reg_addr_i) == sysint_pkg::ADDR_IRQ_FIRST
		|-> reg_rdata_o[1:0] == 2'b00)
		else $error("first status low bits not zero");
	irq_high_zero_a: assert property (
		$past(reg_rd_i) && $past(reg_addr_i) == sysint_pkg::ADDR_IRQ_THIRD
		|-> reg_rdata_o[7:2] == 6'h00)
		else $error("third status high bits not zero");
	overflow_pace_a: assert property (
		counter_overflow_o |-> $past(crystal_fall_i))
		else $error("counter overflow without a crystal edge");
	cover property (stack_start_o);
	cover property (force_software_interrupt_o);
	cover property (stop_exec_i ##1 !crystal_clock_en_o);
endmodule : sysint_core_props

bind sysint_core sysint_core_props chk (.clk_sys_i, .sys_rst_i, .reg_addr_i,
	.reg_rd_i, .reg_rdata_o, .irq_source_i, .irq_enabled_i, .break_req_i,
	.wait_exec_i, .stop_exec_i, .rst_pin_i, .rst_low_voltage_i,
	.crystal_fall_i, .counter_overflow_o, .force_software_interrupt_o,
	.clear_int_mask_o, .stack_start_o, .system_reset_o,
	.cpu_clock_en_o, .periph_clock_en_o, .generator_bus_clock_en_o,
	.crystal_clock_en_o);

/* testbench/sysint_partner.sv */
// crystal oscillator model: falling edge given as a one-cycle pulse
// assumes the crystal clock stands still while its output is disabled
module sysint_partner (
	input  wire logic clk_sys_i,
	input  wire logic sys_rst_i,
	input  wire logic crystal_clock_en_i,
	output logic      crystal_fall_o
);
	timeunit 1ns;
	timeprecision 1ns;
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			crystal_fall_o <= 1'b0;
		else if (!crystal_clock_en_i)
			crystal_fall_o <= 1'b0;
		else
			crystal_fall_o <= ~crystal_fall_o;
	end
endmodule : sysint_partner

/* testbench/system_exception_lowpower_status_tb.sv */
// self-checking bench of the system integration core
// assumes short recovery counts set by parameter, one 100 MHz clock
module system_exception_lowpower_status_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int LONG_N = 64;
	localparam int SHORT_N = 4;
	localparam int PWR = 6, BRK = 7, WAI = 8, STP = 9, CLR = 10;
	logic        clk_sys_i = 1'b0;
	logic        sys_rst_i, reg_wr_i, reg_rd_i, irq_enabled_i;
	logic        short_stop_recovery_i, wdog_off, crystal_clock_en_o;
	logic        crystal_fall_i, stack_start_o, flag_clear_allow_o, watchdog_run_o;
	logic [15:0] reg_addr_i;
	logic [16:1] irq_source_i, v;
	logic [7:0]  reg_wdata_i, reg_rdata_o;
	logic [10:0] strb;
	int          seed = 47, n_fail = 0, total_checks = 0, falls, n_rec;
	always #5 clk_sys_i = ~clk_sys_i;
	sysint_core #(.RECOVERY_LONG(LONG_N), .RECOVERY_SHORT(SHORT_N)) uut (
		.clk_sys_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
		.reg_rdata_o, .irq_source_i, .irq_enabled_i, .break_req_i(strb[BRK]),
		.wait_exec_i(strb[WAI]), .stop_exec_i(strb[STP]), .crystal_fall_i,
		.short_stop_recovery_i, .watchdog_disable_option_i(wdog_off),
		.power_on_i(strb[PWR]), .rst_pin_i(strb[5]), .rst_watchdog_i(strb[4]),
		.rst_bad_opcode_i(strb[3]), .rst_bad_fetch_i(strb[2]),
		.rst_monitor_i(strb[1]), .rst_low_voltage_i(strb[0]),
		.flag_clear_req_i(strb[CLR]), .flag_clear_allow_o,
		.force_software_interrupt_o(), .clear_int_mask_o(), .stack_start_o,
		.system_reset_o(), .cpu_clock_en_o(), .periph_clock_en_o(),
		.generator_bus_clock_en_o(), .crystal_clock_en_o, .watchdog_run_o,
		.counter_overflow_o());
	sysint_partner model (.clk_sys_i, .sys_rst_i,
		.crystal_clock_en_i(crystal_clock_en_o), .crystal_fall_o(crystal_fall_i));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic check(input string nm, input logic [7:0] seen, exp);
		total_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task automatic finish_test();
		if (n_fail == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : finish_test
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_sys_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge clk_sys_i);
		reg_wr_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		@(posedge clk_sys_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge clk_sys_i);
		reg_rd_i <= 1'b0;
		#1 check($sformatf("reg %h", a), reg_rdata_o, e);
	endtask : rd
	task automatic pulse(input int i);
		@(posedge clk_sys_i);
		strb <= 11'h1 << i;
		@(posedge clk_sys_i);
		strb <= 11'h0;
	endtask : pulse
	task automatic allow(input logic e);
		pulse(CLR);
		#1 check("clear allow", {7'h0, flag_clear_allow_o}, {7'h0, e});
	endtask : allow
	// src below zero wakes by interrupt, else by pulsing that strobe
	task automatic wake(input int src, mx, output int f);
		int n;
		f = 0;
		n = 0;
		@(posedge clk_sys_i);
		if (src < 0) begin
			irq_source_i <= 16'h0001;
			irq_enabled_i <= 1'b1;
		end else
			strb <= 11'h1 << src;
		do begin
			@(posedge clk_sys_i);
			#1 n++;
			strb <= 11'h0;
			f += int'(crystal_fall_i && !stack_start_o);
		end while (stack_start_o !== 1'b1 && n < mx);
		check("stack start", {7'h0, stack_start_o}, 8'h01);
		irq_enabled_i <= 1'b0;
		irq_source_i <= 16'h0;
	endtask : wake
	function automatic logic [7:0] irq_exp(int r, logic [16:1] s);
		return r == 0 ? {s[6:1], 2'b00} : r == 1 ? s[14:7] : {6'h00, s[16:15]};
	endfunction : irq_exp
	function automatic logic [7:0] src_exp(int i);
		return i >= 2 ? 8'h01 << (i + 1) : 8'h01 << i;
	endfunction : src_exp
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial begin
		{strb, reg_wr_i, reg_rd_i, irq_enabled_i} = '0;
		{short_stop_recovery_i, wdog_off} = '0;
		{reg_addr_i, reg_wdata_i, irq_source_i} = '0;
		sys_rst_i = 1'b1;
		repeat (3) @(posedge clk_sys_i);
		sys_rst_i <= 1'b0;
		rd(sysint_pkg::ADDR_RESET_SOURCE, 8'h80);
		rd(sysint_pkg::ADDR_RESET_SOURCE, 8'h00);
		for (int i = 0; i < 6; i++) begin
			pulse(i);
			rd(sysint_pkg::ADDR_RESET_SOURCE, src_exp(i));
		end
		pulse(5);
		pulse(PWR);
		rd(sysint_pkg::ADDR_RESET_SOURCE, 8'h80);
		rd(16'hfe02, 8'h00);
		for (int i = 0; i < 6; i++) begin
			v = i == 0 ? 16'hffff : 16'($random(seed));
			wr(sysint_pkg::ADDR_IRQ_FIRST, 8'hff);
			irq_source_i <= v;
			for (int r = 0; r < 3; r++)
				rd(sysint_pkg::ADDR_IRQ_FIRST + 16'(r), irq_exp(r, v));
		end
		irq_source_i <= 16'h0;
		wr(sysint_pkg::ADDR_BREAK_CTRL, 8'h00);
		pulse(BRK);
		allow(1'b0);
		wr(sysint_pkg::ADDR_BREAK_CTRL, 8'h01);
		rd(sysint_pkg::ADDR_BREAK_CTRL, 8'h01);
		allow(1'b1);
		wr(sysint_pkg::ADDR_BREAK_CTRL, 8'h00);
		allow(1'b0);
		pulse(WAI);
		#1 check("watchdog run", {7'h0, watchdog_run_o}, 8'h01);
		wake(-1, 50, falls);
		allow(1'b1);
		wdog_off <= 1'b1;
		pulse(WAI);
		#1 check("watchdog off", {7'h0, watchdog_run_o}, 8'h00);
		wake(BRK, 50, falls);
		wdog_off <= 1'b0;
		rd(sysint_pkg::ADDR_BREAK_EXIT, 8'h02);
		wr(sysint_pkg::ADDR_BREAK_EXIT, 8'h02);
		rd(sysint_pkg::ADDR_BREAK_EXIT, 8'h02);
		wr(sysint_pkg::ADDR_BREAK_EXIT, 8'h00);
		rd(sysint_pkg::ADDR_BREAK_EXIT, 8'h00);
		pulse(WAI);
		wake(BRK, 50, falls);
		sys_rst_i <= 1'b1;
		@(posedge clk_sys_i);
		sys_rst_i <= 1'b0;
		rd(sysint_pkg::ADDR_BREAK_EXIT, 8'h00);
		for (int s = 0; s < 2; s++) begin
			n_rec = s ? SHORT_N : LONG_N;
			short_stop_recovery_i <= s[0];
			pulse(STP);
			repeat (20) @(posedge clk_sys_i);
			wake(-1, 9000, falls);
			check("recovery", {7'h0, falls >= n_rec && falls <= n_rec + 1}, 8'h01);
		end
		finish_test();
	end
	initial begin
		#200000;
		n_fail++;
		finish_test();
	end
endmodule : system_exception_lowpower_status_tb
